// >>> mag_pkg.sv
// Constants and state type of the external memory address and chip enable generator
package mag_pkg;
	// Register offsets
	localparam logic [7:0] OFS_STK_LOW    = 8'h81;
	localparam logic [7:0] OFS_P4CFG      = 8'h92;
	localparam logic [7:0] OFS_MERGE      = 8'h96;
	localparam logic [7:0] OFS_STK_EXT    = 8'h9B;
	localparam logic [7:0] OFS_PAGE       = 8'h9C;
	localparam logic [7:0] OFS_ADDR_CTRL  = 8'h9D;
	localparam logic [7:0] OFS_PORT2      = 8'hA0;
	localparam logic [7:0] OFS_P5CFG      = 8'hA2;
	localparam logic [7:0] OFS_P6CFG      = 8'hB2;
	localparam logic [7:0] OFS_UNLOCK     = 8'hC7;
	localparam logic [7:0] OFS_MOVE_UPPER = 8'hEA;
	// Timed access
	localparam logic [7:0] UNLOCK_FIRST   = 8'hAA;
	localparam logic [7:0] UNLOCK_SECOND  = 8'h55;
	localparam logic [1:0] UNLOCK_WINDOW  = 2'h3;
	// Bits that need the timed access window
	localparam logic [7:0] PROT_ADDR_CTRL = 8'h3F;
	localparam logic [7:0] PROT_P4      = 8'h3F;
	localparam logic [7:0] PROT_P5      = 8'h07;
	localparam logic [7:0] PROT_P6      = 8'h3F;
	// Field positions
	localparam int MODE_LSB             = 0;
	localparam int STACK_MODE_BIT       = 2;
	localparam int CFG_LOW_LSB          = 0;
	localparam int CFG_HIGH_LSB         = 3;
	localparam int MERGE_BIT            = 0;
	// Address modes
	localparam logic [1:0] MODE_16      = 2'h0;
	localparam logic [1:0] MODE_PAGED   = 2'h1;
	localparam logic [1:0] MODE_CONTIG  = 2'h2;
	// Reset values, internal ROM disabled
	localparam logic [7:0] RST_ADDR_CTRL = 8'h00;
	localparam logic [7:0] RST_P4       = 8'h3F;
	localparam logic [7:0] RST_P5       = 8'h00;
	localparam logic [7:0] RST_P6       = 8'h00;
	localparam logic [7:0] RST_OTHER    = 8'h00;
	// Reset values, internal ROM enabled
	localparam logic [7:0] ROM_ADDR_CTRL = 8'h02;
	localparam logic [7:0] ROM_P4       = 8'h2F;
	localparam logic [7:0] ROM_P6       = 8'h07;
	// Cycles after reset release before the straps are trusted
	localparam logic [1:0] STRAP_DELAY  = 2'h3;
	// Address width and size steps
	localparam logic [4:0] SHIFT_32K    = 5'h0F;
	localparam logic [4:0] SHIFT_128K   = 5'h11;
	localparam logic [3:0] NO_CE        = 4'h8;

	typedef struct packed {
		logic [7:0]  addr_ctrl;
		logic [7:0]  p4cfg;
		logic [7:0]  p5cfg;
		logic [7:0]  p6cfg;
		logic [7:0]  stk_low;
		logic [7:0]  stk_ext;
		logic [7:0]  page;
		logic [7:0]  port2;
		logic [7:0]  move_upper;
		logic [7:0]  merge;
		logic        unlock_armed;
		logic [1:0]  unlock_win;
		logic [1:0]  init_cnt;
		logic        rom_s1;
		logic        rom_s2;
		logic        mux_s1;
		logic        mux_s2;
		logic        lsb_on_p7;
		logic [7:0]  rdata;
		logic [21:0] addr;
		logic [5:0]  addr_line_en;
		logic [7:0]  ce_n;
		logic [3:0]  pce_n;
		logic        bus_valid;
		logic        program_cycle;
		logic [15:0] stack_addr;
		logic        extra_cycle;
		logic        pc_wide;
	} mag_state_t;
endpackage

// >>> mag_gen.sv
// External memory address, chip enable and configuration register logic
`timescale 1ns/10ps

// Summary of operation
// R1 - Mode field: 00 16-bit, 01 paged 24-bit, 1x contiguous 24-bit.
// R2 - Mode resets to 16-bit without internal ROM, contiguous with ROM.
// R3 - 16-bit mode limits program and data reach to 64kB.
// R4 - Paged mode adds a cycle to calls, returns and interrupt entry.
// R5 - Paged mode fetches interrupt vectors with upper address byte zero.
// R6 - Contiguous mode keeps and saves a full 24-bit program counter.
// R7 - Contiguous mode adds one cycle to the pointer increment instruction.
// R8 - Pointer data moves use extension, high and low pointer bytes.
// R9 - Indirect data moves use upper register, port 2 latch and index.
// R10 - Paged mode takes program address bits 23-16 from the page register.
// R11 - Ten-bit stack address is extended pointer over stack pointer. Code uses all eight bits of the extension byte, giving 16 bits.
// R12 - Port 4 field enables zero to six upper address lines, default all.
// R13 - Port 4 and port 6 fields each enable up to four program enables.
// R14 - Port 5 field enables up to four peripheral enables, default none.
// R15 - Port 6 field sets data size per peripheral enable, 32kB to 1MB.
// R16 - Up to 16MB code over 22 address lines and eight enables.
// R17 - Up to 4MB data over the same buses with peripheral enables.
// R18 - Merged 16MB program and data map is supported.
// R19 - Multiplex pin high at reset puts low address on port 7.
// R20 - With ROM, reset to 2MB per enable and upper four enables on.
// R21 - Protected fields change only in the timed access window.
// R22 - Assert the one enable whose index is address over size.
module mag_gen (
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        rom_enable_i,
	input  wire logic        mux_select_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        fetch_req_i,
	input  wire logic        vector_fetch_i,
	input  wire logic [23:0] pc_i,
	input  wire logic        ptr_move_req_i,
	input  wire logic [7:0]  pointer_extension_byte_i,
	input  wire logic [7:0]  pointer_high_byte_i,
	input  wire logic [7:0]  pointer_low_byte_i,
	input  wire logic        ind_move_req_i,
	input  wire logic [7:0]  indirect_register_i,
	input  wire logic        call_return_i,
	input  wire logic        irq_entry_i,
	input  wire logic        pointer_increment_instr_i,
	output logic      [21:0] addr_o,
	output logic      [5:0]  addr_line_en_o,
	output logic      [7:0]  ce_n_o,
	output logic      [3:0]  peripheral_chip_enable_n_o,
	output logic             bus_valid_o,
	output logic             program_cycle_o,
	output logic             lsb_on_p7_o,
	output logic      [15:0] stack_addr_o,
	output logic             extra_cycle_o,
	output logic             pc_wide_o
);

	mag_pkg::mag_state_t s_q;
	mag_pkg::mag_state_t s_d;

	// Size step of a three-bit size code as a shift amount
	function automatic logic [4:0] size_shift(input logic [2:0] code);
		logic [4:0] r;
		r = mag_pkg::SHIFT_32K;
		if (code != 3'h0) begin
			r = mag_pkg::SHIFT_128K + {2'h0, code} - 5'h01;
		end
		if (code > 3'h6) begin
			r = mag_pkg::SHIFT_128K + 5'h05;
		end
		return r;
	endfunction

	// Number of enables granted by a three-bit enable code
	function automatic logic [2:0] ce_count(input logic [2:0] code);
		logic [2:0] r;
		r = 3'h0;
		if (code[2]) begin
			r = {1'b0, code[1:0]} + 3'h1;
		end
		return r;
	endfunction

	// Index of the enable addressed, or NO_CE when out of reach
	function automatic logic [3:0] ce_index(input logic [23:0] a, input logic [4:0] sh,
	                                       input logic [2:0] n_lo, input logic [2:0] n_hi);
		logic [23:0] idx;
		logic [3:0]  r;
		idx = a >> sh;
		r = mag_pkg::NO_CE;
		if (idx < 24'h4) begin
			if (idx[2:0] < n_lo) begin
				r = {1'b0, idx[2:0]};
			end
		end else if (idx < 24'h8) begin
			if ({1'b0, idx[1:0]} < n_hi) begin
				r = {1'b0, idx[2:0]};
			end
		end
		return r;
	endfunction

	// Protected bits take the write only inside the window
	function automatic logic [7:0] guarded(input logic [7:0] old, input logic [7:0] wd,
	                                      input logic [7:0] prot, input logic open);
		logic [7:0] r;
		r = (old & prot) | (wd & ~prot);
		if (open) begin
			r = wd;
		end
		return r;
	endfunction

	always_comb begin
		logic [1:0]  mode;
		logic        paged;
		logic        contig;
		logic        win_open;
		logic [23:0] a;
		logic [3:0]  idx;
		logic [2:0]  lines;
		logic        use_prog;
		logic        data_move;
		s_d = s_q;
		a = 24'h0;
		idx = mag_pkg::NO_CE;
		lines = 3'h0;
		use_prog = 1'b0;
		data_move = ptr_move_req_i || ind_move_req_i;
		mode = s_q.addr_ctrl[mag_pkg::MODE_LSB +: 2];
		paged = (mode == mag_pkg::MODE_PAGED); // R1
		contig = mode[1]; // R1
		win_open = (s_q.unlock_win != 2'h0);

		// Straps pass two flops before use
		s_d.rom_s1 = rom_enable_i;
		s_d.rom_s2 = s_q.rom_s1;
		s_d.mux_s1 = mux_select_i;
		s_d.mux_s2 = s_q.mux_s1;

		// Window counts down one step per cycle
		if (win_open) begin
			s_d.unlock_win = s_q.unlock_win - 2'h1;
		end

		if (reg_wr_i) begin
			// Any write but another first key drops a pending first key
			s_d.unlock_armed = 1'b0;
			case (reg_addr_i)
				mag_pkg::OFS_UNLOCK: begin
					if (reg_wdata_i == mag_pkg::UNLOCK_FIRST) begin
						s_d.unlock_armed = 1'b1;
					end else if (s_q.unlock_armed && reg_wdata_i == mag_pkg::UNLOCK_SECOND) begin
						s_d.unlock_win = mag_pkg::UNLOCK_WINDOW; // R21
					end
				end
				mag_pkg::OFS_ADDR_CTRL: begin
					s_d.addr_ctrl = guarded(s_q.addr_ctrl, reg_wdata_i, mag_pkg::PROT_ADDR_CTRL, win_open); // R21
				end
				mag_pkg::OFS_P4CFG: begin
					s_d.p4cfg = guarded(s_q.p4cfg, reg_wdata_i, mag_pkg::PROT_P4, win_open); // R21
				end
				mag_pkg::OFS_P5CFG: begin
					s_d.p5cfg = guarded(s_q.p5cfg, reg_wdata_i, mag_pkg::PROT_P5, win_open); // R21
				end
				mag_pkg::OFS_P6CFG: begin
					s_d.p6cfg = guarded(s_q.p6cfg, reg_wdata_i, mag_pkg::PROT_P6, win_open); // R21
				end
				mag_pkg::OFS_STK_LOW: begin
					s_d.stk_low = reg_wdata_i;
				end
				mag_pkg::OFS_STK_EXT: begin
					s_d.stk_ext = reg_wdata_i;
				end
				mag_pkg::OFS_PAGE: begin
					s_d.page = reg_wdata_i;
				end
				mag_pkg::OFS_PORT2: begin
					s_d.port2 = reg_wdata_i;
				end
				mag_pkg::OFS_MOVE_UPPER: begin
					s_d.move_upper = reg_wdata_i;
				end
				mag_pkg::OFS_MERGE: begin
					s_d.merge = reg_wdata_i;
				end
				default: begin
				end
			endcase
		end

		// Defaults follow the ROM strap once it has settled
		if (s_q.init_cnt != mag_pkg::STRAP_DELAY) begin
			s_d.init_cnt = s_q.init_cnt + 2'h1;
			if (s_q.init_cnt == mag_pkg::STRAP_DELAY - 2'h1) begin
				s_d.lsb_on_p7 = s_q.mux_s2; // R19
				if (s_q.rom_s2) begin
					s_d.addr_ctrl = mag_pkg::ROM_ADDR_CTRL; // R2
					s_d.p4cfg = mag_pkg::ROM_P4; // R20
					s_d.p6cfg = mag_pkg::ROM_P6; // R20
				end
			end
		end

		// Read data stands for one cycle only, zero otherwise
		s_d.rdata = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				mag_pkg::OFS_ADDR_CTRL: begin
					s_d.rdata = s_q.addr_ctrl;
				end
				mag_pkg::OFS_P4CFG: begin
					s_d.rdata = s_q.p4cfg;
				end
				mag_pkg::OFS_P5CFG: begin
					s_d.rdata = s_q.p5cfg;
				end
				mag_pkg::OFS_P6CFG: begin
					s_d.rdata = s_q.p6cfg;
				end
				mag_pkg::OFS_STK_LOW: begin
					s_d.rdata = s_q.stk_low;
				end
				mag_pkg::OFS_STK_EXT: begin
					s_d.rdata = s_q.stk_ext;
				end
				mag_pkg::OFS_PAGE: begin
					s_d.rdata = s_q.page;
				end
				mag_pkg::OFS_PORT2: begin
					s_d.rdata = s_q.port2;
				end
				mag_pkg::OFS_MOVE_UPPER: begin
					s_d.rdata = s_q.move_upper;
				end
				mag_pkg::OFS_MERGE: begin
					s_d.rdata = s_q.merge;
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end

		// Address source, program fetch first
		if (fetch_req_i) begin
			use_prog = 1'b1;
			if (contig) begin
				a = pc_i; // R6
			end else if (paged && !vector_fetch_i) begin
				a = {s_q.page, pc_i[15:0]}; // R10
			end else begin
				a = {8'h00, pc_i[15:0]}; // R3 R5
			end
		end else if (ptr_move_req_i) begin
			a = {pointer_extension_byte_i, pointer_high_byte_i, pointer_low_byte_i}; // R8
		end else if (ind_move_req_i) begin
			a = {s_q.move_upper, s_q.port2, indirect_register_i}; // R9
		end
		// Sixteen-bit mode keeps data moves inside the low 64kB
		if (!fetch_req_i && mode == mag_pkg::MODE_16) begin
			a[23:16] = 8'h00; // R3
		end

		// Upper address lines present on pins
		lines = s_q.p4cfg[mag_pkg::CFG_HIGH_LSB +: 3];
		if (lines == 3'h7) begin
			lines = 3'h6;
		end
		for (int i = 0; i < 6; i++) begin
			s_d.addr_line_en[i] = (i < int'(lines)); // R12
		end
		s_d.addr = {a[21:16] & s_d.addr_line_en, a[15:0]}; // R16

		// Merged map only steers real data moves, an idle cycle selects nothing
		s_d.ce_n = 8'hFF;
		s_d.pce_n = 4'hF;
		if (use_prog || (s_q.merge[mag_pkg::MERGE_BIT] && data_move)) begin
			// Merged map sends data moves through the program enables
			idx = ce_index(a, size_shift(s_q.p4cfg[mag_pkg::CFG_HIGH_LSB +: 3]),
			               ce_count(s_q.p4cfg[mag_pkg::CFG_LOW_LSB +: 3]),
			               ce_count(s_q.p6cfg[mag_pkg::CFG_LOW_LSB +: 3])); // R13 R18 R22
			if (!idx[3]) begin
				s_d.ce_n[idx[2:0]] = 1'b0; // R22
			end
		end else if (data_move) begin
			idx = ce_index(a, size_shift(s_q.p6cfg[mag_pkg::CFG_HIGH_LSB +: 3] > 3'h4 ? 3'h4 :
			                              s_q.p6cfg[mag_pkg::CFG_HIGH_LSB +: 3]),
			               ce_count(s_q.p5cfg[mag_pkg::CFG_LOW_LSB +: 3]), 3'h0); // R14 R15 R17
			if (!idx[3]) begin
				s_d.pce_n[idx[1:0]] = 1'b0; // R17
			end
		end
		s_d.bus_valid = fetch_req_i || data_move;
		s_d.program_cycle = use_prog;

		// Stack mode bit puts the whole extended pointer byte above stack pointer
		if (s_q.addr_ctrl[mag_pkg::STACK_MODE_BIT]) begin
			s_d.stack_addr = {s_q.stk_ext, s_q.stk_low}; // R11
		end else begin
			s_d.stack_addr = {8'h00, s_q.stk_low};
		end

		// Core stretches the instruction by one cycle when this is set
		s_d.extra_cycle = (paged && (call_return_i || irq_entry_i)) ||
		                  (contig && pointer_increment_instr_i); // R4 R7
		s_d.pc_wide = contig; // R6
	end

	// Async reset loads constants only; strap defaults arrive after release
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.addr_ctrl <= mag_pkg::RST_ADDR_CTRL; // R2
			s_q.p4cfg <= mag_pkg::RST_P4; // R12 R13
			s_q.p5cfg <= mag_pkg::RST_P5; // R14
			s_q.p6cfg <= mag_pkg::RST_P6; // R15
			s_q.stk_low <= mag_pkg::RST_OTHER;
			s_q.stk_ext <= mag_pkg::RST_OTHER;
			s_q.page <= mag_pkg::RST_OTHER;
			s_q.port2 <= mag_pkg::RST_OTHER;
			s_q.move_upper <= mag_pkg::RST_OTHER;
			s_q.merge <= mag_pkg::RST_OTHER;
			s_q.ce_n <= 8'hFF;
			s_q.pce_n <= 4'hF;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o = s_q.rdata;
	assign addr_o = s_q.addr;
	assign addr_line_en_o = s_q.addr_line_en;
	assign ce_n_o = s_q.ce_n;
	assign peripheral_chip_enable_n_o = s_q.pce_n;
	assign bus_valid_o = s_q.bus_valid;
	assign program_cycle_o = s_q.program_cycle;
	assign lsb_on_p7_o = s_q.lsb_on_p7;
	assign stack_addr_o = s_q.stack_addr;
	assign extra_cycle_o = s_q.extra_cycle;
	assign pc_wide_o = s_q.pc_wide;

endmodule

// >>> mag_mem_model.sv
// Behavioural external program and data memories on the enables
`timescale 1ns/10ps
module mag_mem_model (
	input  wire logic [7:0] ce_n_i,
	input  wire logic [3:0] pce_n_i,
	input  wire logic       valid_i,
	output logic      [3:0] dev_o
);
	// Device selected: 0-7 program, 8-11 data, F none
	always_comb begin
		dev_o = 4'hF;
		for (int i = 0; i < 8; i++) begin
			if (valid_i && !ce_n_i[i]) dev_o = 4'(i);
		end
		for (int i = 0; i < 4; i++) begin
			if (valid_i && !pce_n_i[i]) dev_o = 4'(8 + i);
		end
	end
endmodule

// >>> mag_gen_assertions.sv
// Checker on the generator's ports
`timescale 1ns/10ps
module mag_gen_checker (
	input wire logic        sys_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        fetch_req_i,
	input wire logic [23:0] pc_i,
	input wire logic        ptr_move_req_i,
	input wire logic        ind_move_req_i,
	input wire logic        call_return_i,
	input wire logic        pointer_increment_instr_i,
	input wire logic [21:0] addr_o,
	input wire logic [5:0]  addr_line_en_o,
	input wire logic [7:0]  ce_n_o,
	input wire logic [3:0]  peripheral_chip_enable_n_o,
	input wire logic        bus_valid_o,
	input wire logic        program_cycle_o,
	input wire logic        extra_cycle_o,
	input wire logic        pc_wide_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	wire req = fetch_req_i || ptr_move_req_i || ind_move_req_i;
	rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data left standing");
	bus_idle_a: assert property (!req |=> !bus_valid_o && ce_n_o == 8'hFF && peripheral_chip_enable_n_o == 4'hF)
		else $error("enable active without request");
	bus_valid_a: assert property (req |=> bus_valid_o)
		else $error("request not answered");
	fetch_mark_a: assert property (fetch_req_i |=> program_cycle_o && peripheral_chip_enable_n_o == 4'hF)
		else $error("fetch not marked as program cycle");
	// Config must be settled for a cycle, pc_wide_o lags a write
	wide_addr_a: assert property (fetch_req_i && pc_wide_o && addr_line_en_o == 6'h3F && !reg_wr_i && !$past(reg_wr_i)
		|=> addr_o == 22'($past(pc_i)))
		else $error("contiguous fetch address wrong");
	one_ce_a: assert property ($onehot0(~ce_n_o))
		else $error("several program enables active");
	one_pce_a: assert property ($onehot0(~peripheral_chip_enable_n_o))
		else $error("several peripheral enables active");
	line_mask_a: assert property ((addr_o[21:16] & ~addr_line_en_o) == 6'h00)
		else $error("upper address on a pin that is not an address line");
	incr_extra_a: assert property (pointer_increment_instr_i && pc_wide_o && !$past(reg_wr_i) |=> extra_cycle_o)
		else $error("pointer increment without extra cycle");
	cover property (fetch_req_i && pc_wide_o);
	cover property (ptr_move_req_i ##1 peripheral_chip_enable_n_o != 4'hF);
	cover property (call_return_i ##1 extra_cycle_o);
endmodule
bind mag_gen mag_gen_checker chk_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fetch_req_i(fetch_req_i), .pc_i(pc_i),
	.ptr_move_req_i(ptr_move_req_i), .ind_move_req_i(ind_move_req_i), .call_return_i(call_return_i),
	.pointer_increment_instr_i(pointer_increment_instr_i), .addr_o(addr_o), .addr_line_en_o(addr_line_en_o),
	.ce_n_o(ce_n_o), .peripheral_chip_enable_n_o(peripheral_chip_enable_n_o), .bus_valid_o(bus_valid_o),
	.program_cycle_o(program_cycle_o), .extra_cycle_o(extra_cycle_o), .pc_wide_o(pc_wide_o));

// >>> test_mag_gen.sv
// Self-checking bench for the address and chip enable generator
`timescale 1ns/10ps
module test_mag_gen;
	logic        clk = 1'b0, rst = 1'b1, rom = 1'b0, multiplex_select_pin = 1'b1, wr = 1'b0, rd = 1'b0;
	logic        fe = 1'b0, vf = 1'b0, pm = 1'b0, im = 1'b0, cr = 1'b0, ie = 1'b0, pi = 1'b0;
	logic [7:0]  ra = 8'h00, wd = 8'h00, px = 8'h00, ph = 8'h00, pl = 8'h00, ir = 8'h00;
	logic [23:0] pc = 24'h000000;
	logic [7:0]  rdata, ce_n;
	logic [21:0] addr;
	logic [5:0]  lines;
	logic [3:0]  pce_n, dev;
	logic [15:0] stk;
	logic        valid, prog, p7, xc, wide;
	int          n_mismatch = 0, num_checks = 0, cyc = 0;
	always #25 clk = ~clk;
	mag_gen dut (.sys_clk_i(clk), .sys_rst_i(rst), .rom_enable_i(rom), .mux_select_i(multiplex_select_pin), .reg_addr_i(ra),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .fetch_req_i(fe), .vector_fetch_i(vf),
		.pc_i(pc), .ptr_move_req_i(pm), .pointer_extension_byte_i(px), .pointer_high_byte_i(ph),
		.pointer_low_byte_i(pl), .ind_move_req_i(im), .indirect_register_i(ir), .call_return_i(cr),
		.irq_entry_i(ie), .pointer_increment_instr_i(pi), .addr_o(addr), .addr_line_en_o(lines), .ce_n_o(ce_n),
		.peripheral_chip_enable_n_o(pce_n), .bus_valid_o(valid), .program_cycle_o(prog), .lsb_on_p7_o(p7),
		.stack_addr_o(stk), .extra_cycle_o(xc), .pc_wide_o(wide));
	mag_mem_model mem (.ce_n_i(ce_n), .pce_n_i(pce_n), .valid_i(valid), .dev_o(dev));
	task automatic print_verdict;
		if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask
	// One request cycle; outputs are looked at once that edge's updates landed
	task automatic go;
		@(posedge clk);
		{wr, rd, fe, vf, pm, im, cr, ie, pi} <= 9'h000;
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		{ra, wd, wr} <= {a, d, 1'b1};
		go;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		{ra, rd} <= {a, 1'b1};
		go;
		chk($sformatf("reg %h", a), e, rdata);
	endtask
	task automatic unlock_wr(input logic [7:0] a, input logic [7:0] d);
		wreg(8'hC7, 8'hAA);
		wreg(8'hC7, 8'h55);
		wreg(a, d);
	endtask
	task automatic fetch(input logic [23:0] p, input logic [21:0] ea, input logic [7:0] ece);
		{fe, pc} <= {1'b1, p};
		go;
		chk("addr", ea, addr);
		chk("ce_n", ece, ce_n);
	endtask
	task automatic dmove(input logic [23:0] a, input logic [21:0] ea, input logic [3:0] ep);
		{pm, px, ph, pl} <= {1'b1, a};
		go;
		chk("addr", ea, addr);
		chk("pce_n", ep, pce_n);
	endtask
	// Straps held steady well past the capture edge
	task automatic rst_dut(input logic r, input logic m);
		{rom, multiplex_select_pin, rst} <= {r, m, 1'b1};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic t_reset;
		rst_dut(1'b0, 1'b1);
		chk("p7", 1'b1, p7);
		rreg(8'h9D, 8'h00);
		rreg(8'h92, 8'h3F);
		rreg(8'hA2, 8'h00);
		rreg(8'hB2, 8'h00);
		rreg(8'h50, 8'h00);
		rreg(8'hC7, 8'h00);
		go;
		chk("idle", 9'h0FF, {valid, ce_n});
		fetch(24'h000123, 22'h000123, 8'hFE);
		chk("valid", 2'h3, {valid, prog});
	endtask
	task automatic t_timed;
		wreg(8'h9D, 8'h02);
		rreg(8'h9D, 8'h00);
		wreg(8'hC7, 8'hAA);
		wreg(8'hC7, 8'h55);
		repeat (3) wreg(8'h9C, 8'h07);
		wreg(8'h9D, 8'h03);
		rreg(8'h9D, 8'h00);
		unlock_wr(8'h9D, 8'h03);
		rreg(8'h9D, 8'h03);
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			unlock_wr(8'h9D, 8'(m));
			for (int v = 0; v < 2; v++) begin
				vf <= v[0];
				fetch(24'h2A1234, m > 1 ? 22'h2A1234 : (m == 1 && v == 0) ? 22'h071234 : 22'h001234, 8'hFE);
				chk("wide", m > 1, wide);
			end
			dmove(24'h051234, m == 0 ? 22'h001234 : 22'h051234, 4'hF);
			cr <= 1'b1;
			go;
			chk("call", m == 1, xc);
			ie <= 1'b1;
			go;
			chk("irq", m == 1, xc);
			pi <= 1'b1;
			go;
			chk("incr", m > 1, xc);
		end
	endtask
	task automatic t_data;
		wreg(8'h9B, 8'h03);
		wreg(8'h81, 8'h5A);
		go;
		chk("stack", 16'h005A, stk);
		unlock_wr(8'h9D, 8'h06);
		go;
		chk("stack", 16'h035A, stk);
		unlock_wr(8'hA2, 8'h07);
		dmove(24'h018000, 22'h018000, 4'h7);
		chk("dev", 4'hB, dev);
		unlock_wr(8'hB2, 8'h08);
		dmove(24'h060000, 22'h060000, 4'h7);
		dmove(24'h020000, 22'h020000, 4'hD);
		wreg(8'hA0, 8'h90);
		{im, ir} <= {1'b1, 8'h44};
		go;
		chk("ind", 26'h0009044E, {addr, pce_n});
		wreg(8'h96, 8'h01);
		go;
		chk("merge idle", 9'h0FF, {valid, ce_n});
		dmove(24'h451234, 22'h051234, 4'hF);
		chk("merge ce_n", 8'hFD, ce_n);
		chk("merge dev", 4'h1, dev);
		wreg(8'h96, 8'h00);
	endtask
	task automatic t_cfg;
		unlock_wr(8'h92, 8'h05);
		fetch(24'h00C000, 22'h00C000, 8'hFD);
		chk("lines", 6'h00, lines);
		fetch(24'h010000, 22'h000000, 8'hFF);
		unlock_wr(8'hB2, 8'h0C);
		fetch(24'h020000, 22'h000000, 8'hEF);
		rst_dut(1'b1, 1'b0);
		chk("p7", 1'b0, p7);
		rreg(8'h9D, 8'h02);
		rreg(8'h92, 8'h2F);
		rreg(8'hB2, 8'h07);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			print_verdict;
		end
	end
	initial begin
		t_reset;
		t_timed;
		t_modes;
		t_data;
		t_cfg;
		print_verdict;
	end
endmodule
